// ### design/tmr_cap_pkg.sv
package tmr_cap_pkg;

    // Addresses on the internal bus.
    localparam logic [15:0] ADDR_CTL_XY    = 16'hfff0;
    localparam logic [15:0] ADDR_STAT_XY   = 16'hfff1;
    localparam logic [15:0] ADDR_CMPA_Y    = 16'hfff2;
    localparam logic [15:0] ADDR_CMPB_Y    = 16'hfff3;
    localparam logic [15:0] ADDR_SRC_Y     = 16'hfff5;
    localparam logic [15:0] ADDR_CMPB_X    = 16'hfff7;
    localparam logic [15:0] ADDR_SER_TMR   = 16'hffc3;
    localparam logic [15:0] ADDR_SYS_CTL   = 16'hffc4;
    localparam logic [15:0] ADDR_CONN_SEL  = 16'hfffe;
    localparam logic [15:0] ADDR_CONN_IN   = 16'hfffc;
    localparam logic [15:0] ADDR_OFS_CMP   = 16'hfff4;
    localparam logic [15:0] ADDR_RISE_CAP  = 16'hfff2;
    localparam logic [15:0] ADDR_FALL_CAP  = 16'hfff3;

    // Reset values.
    localparam logic [7:0]  SER_TMR_RST    = 8'h00;
    localparam logic [7:0]  SYS_CTL_RST    = 8'h09;
    localparam logic [7:0]  CONN_SEL_RST   = 8'h00;
    localparam logic [7:0]  CONN_IN_RST    = 8'h00;
    localparam logic [7:0]  OFS_CMP_RST    = 8'hff;
    localparam logic [7:0]  CAP_RST        = 8'h00;
    localparam logic [7:0]  BANK_RST       = 8'h00;

    // Field positions.
    localparam int          SER_ICKS_LO    = 0;
    localparam int          SER_ICKS_HI    = 1;
    localparam int          SYS_HOST_EN_BIT = 1;
    localparam int          CONN_BANK_BIT  = 7;
    localparam int          CONN_START_BIT = 7;
    localparam int          STAT_FLAG_BIT  = 4;
    localparam int          CTL_CKS_LO     = 0;

    // Capture sequencer states; one bit changes per step, except from fall back to idle.
    typedef enum logic [1:0] {
        CAP_IDLE  = 2'b00,
        CAP_RISE  = 2'b01,
        CAP_FALL  = 2'b11
    } cap_state_t;

endpackage : tmr_cap_pkg

// ### design/tmr_cap_if.sv
`timescale 1ns/1ps
// Compare-match sum path between main block and comparator.
interface tmr_cap_if;
    logic [7:0] count;      // Counter value.
    logic [7:0] offset;     // Offset compare register.
    logic [7:0] capture;    // Hidden capture register.
    logic       hold;       // Suppresses the comparison.
    logic       match;      // Compare-match C.
    modport owner (output count, output offset, output capture,
                   output hold, input match);
    modport cmp (input count, input offset, input capture,
                 input hold, output match);
endinterface : tmr_cap_if

// ### design/tmr_cmp_c.sv
`timescale 1ns/1ps
// Compare-match C comparator, registered output.
module tmr_cmp_c (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rstn,
    // Sum path.
    tmr_cap_if.cmp    cif
);
    logic [7:0] sum;  // Wrapping sum.

    // The sum wraps modulo 256 on purpose.
    assign sum = 8'(cif.offset + cif.capture);

    // Match is registered; held low while suppressed.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cif.match <= 1'b0;
        end else begin
            cif.match <= !cif.hold && (cif.count == sum);
        end
    end

    a_match_hold: assert property (@(posedge clk) disable iff (!rstn)
        cif.hold |=> !cif.match)
        else $error("match raised while suppressed");
    a_match_sum: assert property (@(posedge clk) disable iff (!rstn)
        (!cif.hold && cif.count == 8'(cif.offset + cif.capture))
        |=> cif.match)
        else $error("match missed on equal sum");
endmodule : tmr_cmp_c

// ### design/tmr_cap_ctl.sv
`timescale 1ns/1ps
module tmr_cap_ctl (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Hardware standby, clears like reset except the edge detector, read port and compare match C.
    input  wire logic        standby,
    // Internal bus.
    input  wire logic [15:0] addr,
    input  wire logic        rd,
    input  wire logic        wr,
    input  wire logic        second_bus_state,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata,
    output logic             rvalid,
    // Counter side.
    input  wire logic [7:0]  timer_counter,
    input  wire logic        ext_reset,
    input  wire logic [2:0]  clock_select,
    output logic      [4:0]  clock_sel_code,
    // Results.
    output logic             compare_match_c,
    output logic             input_capture_flag,
    output logic             bank_select,
    output logic             host_interface_enable
);
    logic [7:0] ser_tmr_reg;   // Serial/timer control.
    logic [7:0] sys_ctl_reg;   // System control.
    logic [7:0] conn_sel_reg;  // Connection select.
    logic [7:0] conn_in_reg;   // Connection input control.
    logic [7:0] ofs_cmp_reg;   // Offset compare.
    logic [7:0] int_cap_reg;   // Hidden capture.
    logic [7:0] rise_cap_reg;  // Rise capture.
    logic [7:0] fall_cap_reg;  // Fall capture.
    logic       cap_flag_reg;  // Input capture flag.
    logic       ext_dly_reg;   // Previous reset-input level.
    logic       fall_edge;     // Reset input fell.
    logic       rise_edge;     // Reset input rose.
    logic       timer_ok;      // Timer access allowed.
    logic       wr_ser;        // Write strobes.
    logic       wr_sys;
    logic       wr_conn;
    logic       wr_cin;
    logic       wr_ofs;
    logic       wr_stat;
    logic       cap_done;      // Capture pair finished.
    tmr_cap_pkg::cap_state_t cap_state_reg;
    tmr_cap_if  cif ();

    assign fall_edge = ext_dly_reg && !ext_reset;
    assign rise_edge = !ext_dly_reg && ext_reset;

    // Timer and connection registers, except serial/timer control, vanish while the host interface owns
    // the bus, so a stray write cannot disturb a running measurement.
    assign timer_ok = !sys_ctl_reg[tmr_cap_pkg::SYS_HOST_EN_BIT];
    assign wr_ser  = wr && addr == tmr_cap_pkg::ADDR_SER_TMR;
    assign wr_sys  = wr && addr == tmr_cap_pkg::ADDR_SYS_CTL;
    assign wr_conn = wr && timer_ok && addr == tmr_cap_pkg::ADDR_CONN_SEL;
    assign wr_cin  = wr && timer_ok && addr == tmr_cap_pkg::ADDR_CONN_IN;
    // Extension registers live in channel X bank only.
    assign wr_ofs  = wr && timer_ok && !bank_select
                     && addr == tmr_cap_pkg::ADDR_OFS_CMP;
    assign wr_stat = wr && timer_ok && !bank_select
                     && addr == tmr_cap_pkg::ADDR_STAT_XY;
    assign cap_done = cap_state_reg == tmr_cap_pkg::CAP_FALL && fall_edge;

    assign bank_select =
        conn_sel_reg[tmr_cap_pkg::CONN_BANK_BIT];
    assign host_interface_enable =
        sys_ctl_reg[tmr_cap_pkg::SYS_HOST_EN_BIT];
    assign input_capture_flag = cap_flag_reg;
    assign compare_match_c = cif.match;

    // Clock choice code: internal select pair above the three select bits.
    assign clock_sel_code = {ser_tmr_reg[tmr_cap_pkg::SER_ICKS_HI],
                             ser_tmr_reg[tmr_cap_pkg::SER_ICKS_LO],
                             clock_select};

    // Edge detector on the reset input.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext_dly_reg <= 1'b0;
        end else begin
            ext_dly_reg <= ext_reset;
        end
    end

    // Serial/timer control; software keeps reserved bits zero.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ser_tmr_reg <= tmr_cap_pkg::SER_TMR_RST;
        end else if (standby) begin
            ser_tmr_reg <= tmr_cap_pkg::SER_TMR_RST;
        end else if (wr_ser) begin
            ser_tmr_reg <= wdata;
        end
    end

    // System control: only the host-interface bit matters here.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sys_ctl_reg <= tmr_cap_pkg::SYS_CTL_RST;
        end else if (standby) begin
            sys_ctl_reg <= tmr_cap_pkg::SYS_CTL_RST;
        end else if (wr_sys) begin
            sys_ctl_reg <= wdata;
        end
    end

    // Connection select holds the bank bit.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conn_sel_reg <= tmr_cap_pkg::CONN_SEL_RST;
        end else if (standby) begin
            conn_sel_reg <= tmr_cap_pkg::CONN_SEL_RST;
        end else if (wr_conn) begin
            conn_sel_reg <= wdata;
        end
    end

    // Start bit: hardware clear on completion wins over a write.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conn_in_reg <= tmr_cap_pkg::CONN_IN_RST;
        end else if (standby) begin
            conn_in_reg <= tmr_cap_pkg::CONN_IN_RST;
        end else begin
            if (wr_cin) begin
                conn_in_reg <= wdata;
            end
            if (cap_done) begin
                conn_in_reg[tmr_cap_pkg::CONN_START_BIT] <= 1'b0;
            end
        end
    end

    // Offset compare register.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ofs_cmp_reg <= tmr_cap_pkg::OFS_CMP_RST;
        end else if (standby) begin
            ofs_cmp_reg <= tmr_cap_pkg::OFS_CMP_RST;
        end else if (wr_ofs) begin
            ofs_cmp_reg <= wdata;
        end
    end

    // Hidden capture on every fall of the reset input; no bus path.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            int_cap_reg <= tmr_cap_pkg::CAP_RST;
        end else if (standby) begin
            int_cap_reg <= tmr_cap_pkg::CAP_RST;
        end else if (fall_edge) begin
            int_cap_reg <= timer_counter;
        end
    end

    // Rise/fall sequencer, armed by the start bit.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cap_state_reg <= tmr_cap_pkg::CAP_IDLE;
            rise_cap_reg  <= tmr_cap_pkg::CAP_RST;
            fall_cap_reg  <= tmr_cap_pkg::CAP_RST;
        end else if (standby) begin
            cap_state_reg <= tmr_cap_pkg::CAP_IDLE;
            rise_cap_reg  <= tmr_cap_pkg::CAP_RST;
            fall_cap_reg  <= tmr_cap_pkg::CAP_RST;
        end else begin
            case (cap_state_reg)
                tmr_cap_pkg::CAP_IDLE: begin
                    if (conn_in_reg[tmr_cap_pkg::CONN_START_BIT]) begin
                        cap_state_reg <= tmr_cap_pkg::CAP_RISE;
                    end
                end
                tmr_cap_pkg::CAP_RISE: begin
                    if (!conn_in_reg[tmr_cap_pkg::CONN_START_BIT]) begin
                        cap_state_reg <= tmr_cap_pkg::CAP_IDLE;
                    end else if (rise_edge) begin
                        rise_cap_reg  <= timer_counter;
                        cap_state_reg <= tmr_cap_pkg::CAP_FALL;
                    end
                end
                tmr_cap_pkg::CAP_FALL: begin
                    if (fall_edge) begin
                        fall_cap_reg  <= timer_counter;
                        cap_state_reg <= tmr_cap_pkg::CAP_IDLE;
                    end else if (!conn_in_reg[tmr_cap_pkg::CONN_START_BIT])
                    begin
                        cap_state_reg <= tmr_cap_pkg::CAP_IDLE;
                    end
                end
                default: begin
                    cap_state_reg <= tmr_cap_pkg::CAP_IDLE;
                end
            endcase
        end
    end

    // Capture flag: set wins over a software clear by writing zero.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cap_flag_reg <= 1'b0;
        end else if (standby) begin
            cap_flag_reg <= 1'b0;
        end else if (cap_done) begin
            cap_flag_reg <= 1'b1;
        end else if (wr_stat && !wdata[tmr_cap_pkg::STAT_FLAG_BIT]) begin
            cap_flag_reg <= 1'b0;
        end
    end

    // Read mux; blocked regions read zero, still answered with rvalid.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= rd;
            rdata  <= 8'h00;
            if (rd) begin
                if (addr == tmr_cap_pkg::ADDR_SER_TMR) begin
                    rdata <= ser_tmr_reg;
                end else if (addr == tmr_cap_pkg::ADDR_SYS_CTL) begin
                    rdata <= sys_ctl_reg;
                end else if (timer_ok) begin
                    if (addr == tmr_cap_pkg::ADDR_CONN_SEL) begin
                        rdata <= conn_sel_reg;
                    end else if (addr == tmr_cap_pkg::ADDR_CONN_IN) begin
                        rdata <= conn_in_reg;
                    end else if (!bank_select) begin
                        if (addr == tmr_cap_pkg::ADDR_OFS_CMP) begin
                            rdata <= ofs_cmp_reg;
                        end else if (addr == tmr_cap_pkg::ADDR_RISE_CAP)
                        begin
                            rdata <= rise_cap_reg;
                        end else if (addr == tmr_cap_pkg::ADDR_FALL_CAP)
                        begin
                            rdata <= fall_cap_reg;
                        end else if (addr == tmr_cap_pkg::ADDR_STAT_XY)
                        begin
                            rdata <= {3'b000, cap_flag_reg, 4'h0};
                        end
                    end
                end
            end
        end
    end

    // Feed the comparator; suppress in the second bus state of an offset
    // write and in capture cycles, when the sum is still moving.
    assign cif.count   = timer_counter;
    assign cif.offset  = ofs_cmp_reg;
    assign cif.capture = int_cap_reg;
    assign cif.hold    = (second_bus_state
                          && addr == tmr_cap_pkg::ADDR_OFS_CMP)
                         || fall_edge;

    tmr_cmp_c u_cmp (
        .clk  (clk),
        .rstn (rstn),
        .cif  (cif.cmp)
    );

    a_start_clear: assert property (@(posedge clk) disable iff (!rstn)
        (cap_done && !standby)
        |=> !conn_in_reg[tmr_cap_pkg::CONN_START_BIT])
        else $error("start bit not cleared");
    a_flag_set: assert property (@(posedge clk) disable iff (!rstn)
        (cap_done && !standby) |=> cap_flag_reg)
        else $error("capture flag not set");
    a_int_cap: assert property (@(posedge clk) disable iff (!rstn)
        (fall_edge && !standby) |=> int_cap_reg == $past(timer_counter))
        else $error("capture missed");
    a_host_block: assert property (@(posedge clk) disable iff (!rstn)
        (wr && !timer_ok && !standby) |=> $stable(ofs_cmp_reg))
        else $error("blocked write changed register");
    a_standby_clr: assert property (@(posedge clk) disable iff (!rstn)
        standby |=> ser_tmr_reg == tmr_cap_pkg::SER_TMR_RST
                    && conn_sel_reg == tmr_cap_pkg::CONN_SEL_RST)
        else $error("standby did not clear");
    a_ofs_init: assert property (@(posedge clk) disable iff (!rstn)
        standby |=> ofs_cmp_reg == tmr_cap_pkg::OFS_CMP_RST)
        else $error("offset compare not ones");
    a_fall_cap: assert property (@(posedge clk) disable iff (!rstn)
        (cap_done && !standby) |=> fall_cap_reg == $past(timer_counter))
        else $error("fall capture missed");
    a_clk_code: assert property (@(posedge clk) disable iff (!rstn)
        (wr_ser && !standby)
        |=> clock_sel_code[4:3] == $past(wdata[1:0]))
        else $error("clock code mismatch");
endmodule : tmr_cap_ctl

// ### testbench/tb.sv
`timescale 1ns/1ps
// Self-checking bench for the capture and compare control block.
module tb;
    // One table row: address, write flag, write data, expected read.
    typedef struct {
        logic [15:0] a;
        logic        w;
        logic [7:0]  d;
        logic [7:0]  e;
    } row_t;

    logic        clk = 1'b0;   // System clock.
    logic        rstn = 1'b0;  // Active-low reset.
    logic        standby = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        second_bus_state = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  timer_counter = 8'h00;
    logic        ext_reset = 1'b0;
    logic [2:0]  clock_select = 3'h5;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [4:0]  clock_sel_code;
    logic        compare_match_c;
    logic        input_capture_flag;
    logic        bank_select;
    logic        host_interface_enable;
    int          mismatches = 0;  // Failed comparisons.
    int          tests_run = 0;   // All comparisons.
    int          cycles = 0;      // Cycles since time zero.

    // Reset values first, then writes read back, except the capture addresses, which read zero.
    row_t rows [13] = '{
        '{16'hffc3, 1'b0, 8'h00, 8'h00}, '{16'hffc4, 1'b0, 8'h00, 8'h09},
        '{16'hfffe, 1'b0, 8'h00, 8'h00}, '{16'hfffc, 1'b0, 8'h00, 8'h00},
        '{16'hfff4, 1'b0, 8'h00, 8'hff}, '{16'hfff2, 1'b0, 8'h00, 8'h00},
        '{16'hfff3, 1'b0, 8'h00, 8'h00}, '{16'hffc3, 1'b1, 8'h03, 8'h03},
        '{16'hfff4, 1'b1, 8'h5a, 8'h5a}, '{16'hfff2, 1'b1, 8'h77, 8'h00},
        '{16'hfff3, 1'b1, 8'h88, 8'h00}, '{16'hfffe, 1'b1, 8'h7f, 8'h7f},
        '{16'hfffe, 1'b1, 8'h00, 8'h00}
    };

    tmr_cap_ctl DUT (
        .clk                   (clk),
        .rstn                  (rstn),
        .standby               (standby),
        .addr                  (addr),
        .rd                    (rd),
        .wr                    (wr),
        .second_bus_state      (second_bus_state),
        .wdata                 (wdata),
        .rdata                 (rdata),
        .rvalid                (rvalid),
        .timer_counter         (timer_counter),
        .ext_reset             (ext_reset),
        .clock_select          (clock_select),
        .clock_sel_code        (clock_sel_code),
        .compare_match_c       (compare_match_c),
        .input_capture_flag    (input_capture_flag),
        .bank_select           (bank_select),
        .host_interface_enable (host_interface_enable)
    );

    // The clock toggles every half period of 25 ns.
    always #25 clk = ~clk;

    // Prints the counts and the verdict, then stops the run.
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // A hang is cut short well past the expected run length.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t run did not finish", $time);
            give_verdict();
        end
    end

    // Compares one byte result.
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t byte got %h want %h", $time, got, exp);
        end
    endtask : cmp8

    // Compares one single-bit result.
    task automatic cmp1(input logic got, input logic exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t bit got %b want %b", $time, got, exp);
        end
    endtask : cmp1

    // One bus write; it takes effect on the edge where wr is high.
    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1 wr = 1'b0;
    endtask : bus_wr

    // One bus read; the answer stands for the single following cycle.
    task automatic bus_rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1 rd = 1'b1;
        addr = a;
        @(posedge clk);
        #1 rd = 1'b0;
        cmp1(rvalid, 1'b1);
        cmp8(rdata, exp);
    endtask : bus_rd

    // Waits a number of cycles, then lets that edge settle.
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    // One full pulse on the external reset input at two counter values.
    task automatic pulse(input logic [7:0] up, input logic [7:0] dn);
        timer_counter = up;
        idle(2);
        ext_reset = 1'b1;
        idle(3);
        timer_counter = dn;
        idle(2);
        ext_reset = 1'b0;
        idle(3);
    endtask : pulse

    // Main sequence.
    initial begin
        idle(6);
        rstn = 1'b1;
        cmp8({3'b000, clock_sel_code}, 8'h05);
        // Writes keep the reserved serial/timer bits at zero; connection select also gets 7f.
        foreach (rows[i]) begin
            if (rows[i].w) bus_wr(rows[i].a, rows[i].d);
            bus_rd(rows[i].a, rows[i].e);
        end
        // Both select fields join into the counter clock code.
        cmp8({3'b000, clock_sel_code}, 8'h1d);
        // Access blocked while the host-interface bit is set.
        bus_wr(tmr_cap_pkg::ADDR_SYS_CTL, 8'h0b);
        cmp1(host_interface_enable, 1'b1);
        bus_rd(tmr_cap_pkg::ADDR_OFS_CMP, 8'h00);
        bus_wr(tmr_cap_pkg::ADDR_OFS_CMP, 8'h11);
        bus_wr(tmr_cap_pkg::ADDR_SYS_CTL, 8'h09);
        bus_rd(tmr_cap_pkg::ADDR_OFS_CMP, 8'h5a);
        // In bank Y the offset compare address is not mapped.
        bus_wr(tmr_cap_pkg::ADDR_CONN_SEL, 8'h80);
        cmp1(bank_select, 1'b1);
        bus_wr(tmr_cap_pkg::ADDR_OFS_CMP, 8'h22);
        bus_wr(tmr_cap_pkg::ADDR_CONN_SEL, 8'h00);
        cmp1(bank_select, 1'b0);
        bus_rd(tmr_cap_pkg::ADDR_OFS_CMP, 8'h5a);
        // Armed capture: rise, then fall, then the start bit drops.
        bus_wr(tmr_cap_pkg::ADDR_CONN_IN, 8'h80);
        pulse(8'h3c, 8'hc5);
        cmp1(input_capture_flag, 1'b1);
        bus_rd(tmr_cap_pkg::ADDR_RISE_CAP, 8'h3c);
        bus_rd(tmr_cap_pkg::ADDR_FALL_CAP, 8'hc5);
        bus_rd(tmr_cap_pkg::ADDR_CONN_IN, 8'h00);
        bus_wr(tmr_cap_pkg::ADDR_STAT_XY, 8'h00);
        cmp1(input_capture_flag, 1'b0);
        // Unarmed pulse: only the hidden capture follows the fall.
        pulse(8'h11, 8'h11);
        bus_rd(tmr_cap_pkg::ADDR_RISE_CAP, 8'h3c);
        cmp1(input_capture_flag, 1'b0);
        // Offset f0 plus capture 11 wraps to 01.
        bus_wr(tmr_cap_pkg::ADDR_OFS_CMP, 8'hf0);
        timer_counter = 8'h01;
        idle(2);
        cmp1(compare_match_c, 1'b1);
        // The second bus state of an offset write holds off the match.
        @(posedge clk);
        #1 second_bus_state = 1'b1;
        addr = tmr_cap_pkg::ADDR_OFS_CMP;
        @(posedge clk);
        #1 second_bus_state = 1'b0;
        cmp1(compare_match_c, 1'b0);
        idle(1);
        cmp1(compare_match_c, 1'b1);
        timer_counter = 8'h02;
        idle(2);
        cmp1(compare_match_c, 1'b0);
        // Standby clears the control and capture registers like reset.
        bus_wr(tmr_cap_pkg::ADDR_CONN_SEL, 8'h5c);
        standby = 1'b1;
        idle(2);
        standby = 1'b0;
        bus_rd(tmr_cap_pkg::ADDR_SER_TMR, 8'h00);
        bus_rd(tmr_cap_pkg::ADDR_CONN_SEL, 8'h00);
        bus_rd(tmr_cap_pkg::ADDR_OFS_CMP, 8'hff);
        bus_rd(tmr_cap_pkg::ADDR_FALL_CAP, 8'h00);
        // A second reset in mid-run restores the reset values again.
        bus_wr(tmr_cap_pkg::ADDR_OFS_CMP, 8'h33);
        bus_wr(tmr_cap_pkg::ADDR_SER_TMR, 8'h02);
        cmp8({3'b000, clock_sel_code}, 8'h15);
        rstn = 1'b0;
        idle(2);
        rstn = 1'b1;
        cmp8({3'b000, clock_sel_code}, 8'h05);
        bus_rd(tmr_cap_pkg::ADDR_OFS_CMP, 8'hff);
        bus_rd(tmr_cap_pkg::ADDR_SYS_CTL, 8'h09);
        give_verdict();
    end
endmodule : tb
